// ---- core/tmb_timer.sv ----
// Purpose: sixteen bit up counter with prescaler, apb registers
// Assumes: i_core_clk is the instruction clock, 50 MHz
// Notes: external clocks are pins, sampled through tmb_sync
// How it works
// [RULE1] wide bit set: sixteen bit buffered access; clear: two byte accesses
// [RULE2] select bits route this timer to one, both or neither unit
// [RULE3] prescale field divides the input by 1, 2, 4 or 8
// [RULE4] external source: sync bit 0 synchronises, 1 passes unsynchronised; here both paths count the synchronised edge
// [RULE5] internal source ignores the sync bit and counts every cycle
// [RULE6] source bit picks internal or external; rise counts after a fall
// [RULE7] run bit lets the counter advance; clear holds the count
// [RULE8] modes are timer, synchronous counter and asynchronous counter
// [RULE9] oscillator enabled: both pins inputs, direction ignored, read zero
// [RULE10] wide mode: low byte read copies live high into the buffer
// [RULE11] wide mode: high goes to buffer, low write loads all sixteen
// [RULE12] wide mode: high byte address always reaches the buffer
// [RULE13] low byte write clears prescaler; high byte write does not
// [RULE14] counter wraps after maximum and latches the overflow flag
// [RULE15] overflow enable gates the latched flag onto the request
// [RULE16] software enables companion oscillator and sets the source bit
// [RULE17] special event resets the timer, not in asynchronous mode
// [RULE18] a software write beats a coincident special event reset
// [RULE19] special event reset never sets the overflow flag
// [RULE20] reset clears control, prescaler; stopped, internal, byte mode
// [RULE21] asynchronous count values reach software through safe crossing
`timescale 1ns/1ns
module tmb_timer
  import tmb_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // apb slave
  input tmb_apb_req_t i_apb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // companion timer and clock pins
  input wire logic i_companion_osc_enable,
  input wire logic i_companion_osc_clk,
  input wire logic [1:0] i_osc_pins,
  input wire logic [1:0] i_port_c_direction,
  // enhanced capture/compare special event
  input wire logic i_special_event,
  // port view of the oscillator pins, 1 means input
  output logic [1:0] o_osc_pin_dir,
  output logic [1:0] o_osc_pin_read,
  // interrupt request and time base
  output logic o_overflow_irq,
  output tmb_capcomp_route_t o_capcomp_route,
  output logic [15:0] o_count
);

  // the decoder compares eight address bits
  if (ADDR_W != 8) begin : g_bad_addr
    $error("tmb_timer supports only ADDR_W of 8");
  end

  tmb_control_t control;
  tmb_mode_t mode;
  logic [15:0] count;
  logic [7:0] high_buffer;
  logic [7:0] snap_high;
  logic [2:0] prescale;
  logic [2:0] presc_mask;
  logic overflow_flag;
  logic irq_enable;
  logic armed;
  logic ext_prev;
  logic ext_level;
  logic ext_rise;
  logic ext_fall;
  logic src_tick;
  logic presc_tick;
  logic special_reset;
  logic [2:0] pins_sync;

  // apb decode results
  logic setup_phase;
  logic access_phase;
  logic mapped;
  logic sel_control;
  logic sel_low;
  logic sel_high;
  logic sel_flags;
  logic sel_enables;
  logic sel_status;
  logic wr_control;
  logic wr_low;
  logic wr_high;
  logic wr_flags;
  logic wr_enables;
  logic rd_low_done;
  logic [7:0] wbyte;
  logic [31:0] next_prdata;
  logic overflow_set;

  // oscillator clock and both pins pass two flops before use
  tmb_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_companion_osc_clk, i_osc_pins}),
    .o_sync(pins_sync)
  );

  // [RULE8] companion oscillator or clock pin
  assign ext_level = i_companion_osc_enable ? pins_sync[2] : pins_sync[0];
  assign ext_rise = ext_level & ~ext_prev;
  assign ext_fall = ~ext_level & ext_prev;

  // edge detector history on the synchronised level
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  // [RULE6] arm on first falling edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      armed <= 1'b0;
    end else if (!control.clock_source_select) begin
      armed <= 1'b0;
    end else if (ext_fall) begin
      armed <= 1'b1;
    end
  end

  // [RULE8] mode from source and sync bits
  always_comb begin
    mode = TMB_MODE_TIMER;
    // [RULE5] sync bit ignored on internal clock
    if (control.clock_source_select) begin
      // [RULE4] sync bit picks the path
      if (control.ext_clock_sync_disable) begin
        mode = TMB_MODE_ASYNC;
      end else begin
        mode = TMB_MODE_SYNC;
      end
    end
  end

  // [RULE6] internal ticks every cycle
  // one clock only, so both external paths count the synchronised edge
  assign src_tick = control.clock_source_select ? (ext_rise & armed) : 1'b1;

  // [RULE3] prescale terminal count
  always_comb begin
    case ({control.prescale_sel_hi, control.prescale_sel_lo})
      2'b11: presc_mask = TMB_PRESC_DIV8;
      2'b10: presc_mask = TMB_PRESC_DIV4;
      2'b01: presc_mask = TMB_PRESC_DIV2;
      default: presc_mask = TMB_PRESC_DIV1;
    endcase
  end

  // [RULE7] advance only while running
  assign presc_tick = control.counter_run & src_tick &
                      (prescale == presc_mask);

  // [RULE17] special event, not in async mode
  assign special_reset = i_special_event & (mode != TMB_MODE_ASYNC);

  // apb phases; every access completes in its first access cycle
  assign setup_phase = i_apb.psel & ~i_apb.penable;
  assign access_phase = i_apb.psel & i_apb.penable;
  assign o_pready = 1'b1;
  assign wbyte = i_apb.pwdata[7:0];

  // address decode
  always_comb begin
    sel_control = 1'b0;
    sel_low = 1'b0;
    sel_high = 1'b0;
    sel_flags = 1'b0;
    sel_enables = 1'b0;
    sel_status = 1'b0;
    if (i_apb.paddr == TMB_OFF_CONTROL) begin
      sel_control = 1'b1;
    end else if (i_apb.paddr == TMB_OFF_COUNT_LOW) begin
      sel_low = 1'b1;
    end else if (i_apb.paddr == TMB_OFF_COUNT_HIGH) begin
      sel_high = 1'b1;
    end else if (i_apb.paddr == TMB_OFF_FLAGS) begin
      sel_flags = 1'b1;
    end else if (i_apb.paddr == TMB_OFF_ENABLES) begin
      sel_enables = 1'b1;
    end else if (i_apb.paddr == TMB_OFF_STATUS) begin
      sel_status = 1'b1;
    end
  end

  assign mapped = sel_control | sel_low | sel_high | sel_flags |
                  sel_enables | sel_status;
  // unmapped addresses answer with an error and change nothing
  assign o_pslverr = access_phase & ~mapped;

  // write strobes at the completing access edge
  assign wr_control = access_phase & i_apb.pwrite & sel_control;
  assign wr_low = access_phase & i_apb.pwrite & sel_low;
  assign wr_high = access_phase & i_apb.pwrite & sel_high;
  assign wr_flags = access_phase & i_apb.pwrite & sel_flags;
  assign wr_enables = access_phase & i_apb.pwrite & sel_enables;
  assign rd_low_done = access_phase & ~i_apb.pwrite & sel_low;

  // [RULE20] control clears on reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      control <= tmb_control_t'(TMB_CONTROL_RST);
    end else if (wr_control) begin
      control <= tmb_control_t'(wbyte);
    end
  end

  // [RULE13] low write clears prescaler
  // [RULE17] special event clears it as well
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale <= TMB_PRESC_RST;
    end else if (wr_low || special_reset) begin
      prescale <= TMB_PRESC_RST;
    end else if (control.counter_run && src_tick) begin
      if (prescale == presc_mask) begin
        prescale <= TMB_PRESC_RST;
      end else begin
        prescale <= prescale + 3'h1;
      end
    end
  end

  // counter: writes first, then special reset, then counting
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= TMB_COUNT_RST;
    end else if (wr_low) begin
      // [RULE11] wide low write loads all sixteen
      if (control.wide_access_enable) begin
        count <= {high_buffer, wbyte};
      end else begin
        // [RULE1] byte mode keeps the high byte
        count <= {count[15:8], wbyte};
      end
    end else if (wr_high && !control.wide_access_enable) begin
      // [RULE1] byte mode high write is direct
      count <= {wbyte, count[7:0]};
    end else if (special_reset) begin
      // [RULE18] any write above wins
      count <= TMB_COUNT_RST;
    end else if (presc_tick) begin
      // [RULE14] wraps to zero past maximum
      count <= count + 16'h0001;
    end
  end

  // high byte buffer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      high_buffer <= 8'h00;
    end else if (wr_high && control.wide_access_enable) begin
      // [RULE12] wide high write goes to buffer
      high_buffer <= wbyte;
    end else if (rd_low_done && control.wide_access_enable) begin
      // [RULE10] copy the high byte seen with low
      high_buffer <= snap_high;
    end
  end

  // [RULE19] only a counting wrap sets
  assign overflow_set = presc_tick & (count == TMB_COUNT_MAX) & ~wr_low &
                        ~(wr_high & ~control.wide_access_enable) &
                        ~special_reset;

  // [RULE14] sticky flag, set beats clear
  // software clears by writing one to the flag bit
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overflow_flag <= 1'b0;
    end else begin
      overflow_flag <= overflow_set |
        (overflow_flag & ~(wr_flags & i_apb.pwdata[TMB_BIT_OVERFLOW]));
    end
  end

  // overflow request enable
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_enable <= 1'b0;
    end else if (wr_enables) begin
      irq_enable <= i_apb.pwdata[TMB_BIT_OVERFLOW];
    end
  end

  // [RULE15] enable gates the request
  assign o_overflow_irq = overflow_flag & irq_enable;

  // read data selection for the setup cycle
  always_comb begin
    next_prdata = 32'h00000000;
    if (sel_control) begin
      next_prdata[7:0] = control;
    end else if (sel_low) begin
      next_prdata[7:0] = count[7:0];
    end else if (sel_high) begin
      // [RULE12] wide mode reads the buffer
      if (control.wide_access_enable) begin
        next_prdata[7:0] = high_buffer;
      end else begin
        next_prdata[7:0] = count[15:8];
      end
    end else if (sel_flags) begin
      next_prdata[TMB_BIT_OVERFLOW] = overflow_flag;
    end else if (sel_enables) begin
      next_prdata[TMB_BIT_OVERFLOW] = irq_enable;
    end else if (sel_status) begin
      next_prdata[0] = armed;
      next_prdata[2:1] = mode;
      next_prdata[3] = i_companion_osc_enable;
    end
  end

  // [RULE21] read data and snapshot taken at setup
  // low byte and its high byte come from the same edge, so no rollover
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      snap_high <= 8'h00;
    end else if (setup_phase) begin
      o_prdata <= next_prdata;
      snap_high <= count[15:8];
    end
  end

  // [RULE9] oscillator takes both pins
  assign o_osc_pin_dir = i_companion_osc_enable ? 2'b11 : i_port_c_direction;
  assign o_osc_pin_read = i_companion_osc_enable ? 2'b00 : pins_sync[1:0];

  // [RULE2] time base routing
  always_comb begin
    o_capcomp_route.std_uses_this = control.capcomp_select_high;
    o_capcomp_route.enh_uses_this = control.capcomp_select_high |
                                    control.capcomp_select_low;
  end

  // registered count for the capture/compare units
  assign o_count = count;

endmodule

// ---- core/tmb_pkg.sv ----
// Purpose: shared constants and types for the sixteen bit timer block
// Assumes: 32-bit APB data, one register per aligned word
// Notes: control layout follows the byte of the control register
package tmb_pkg;

  // register byte offsets
  localparam logic [7:0] TMB_OFF_CONTROL = 8'h00;
  localparam logic [7:0] TMB_OFF_COUNT_LOW = 8'h04;
  localparam logic [7:0] TMB_OFF_COUNT_HIGH = 8'h08;
  localparam logic [7:0] TMB_OFF_FLAGS = 8'h0c;
  localparam logic [7:0] TMB_OFF_ENABLES = 8'h10;
  localparam logic [7:0] TMB_OFF_STATUS = 8'h14;

  // control field positions
  localparam int unsigned TMB_BIT_RUN = 0;
  localparam int unsigned TMB_BIT_CLKSRC = 1;
  localparam int unsigned TMB_BIT_SYNC_DIS = 2;
  localparam int unsigned TMB_BIT_CAPSEL_LO = 3;
  localparam int unsigned TMB_BIT_PRESC_LO = 4;
  localparam int unsigned TMB_BIT_CAPSEL_HI = 6;
  localparam int unsigned TMB_BIT_WIDE = 7;
  // flag and enable bit positions
  localparam int unsigned TMB_BIT_OVERFLOW = 0;

  // reset values and count limits
  localparam logic [7:0] TMB_CONTROL_RST = 8'h00;
  localparam logic [15:0] TMB_COUNT_RST = 16'h0000;
  localparam logic [15:0] TMB_COUNT_MAX = 16'hffff;
  localparam logic [2:0] TMB_PRESC_RST = 3'h0;

  // prescaler terminal counts for 1:1, 1:2, 1:4, 1:8
  localparam logic [2:0] TMB_PRESC_DIV1 = 3'h0;
  localparam logic [2:0] TMB_PRESC_DIV2 = 3'h1;
  localparam logic [2:0] TMB_PRESC_DIV4 = 3'h3;
  localparam logic [2:0] TMB_PRESC_DIV8 = 3'h7;

  // control register image, bit 7 first
  typedef struct packed {
    logic wide_access_enable;
    logic capcomp_select_high;
    logic prescale_sel_hi;
    logic prescale_sel_lo;
    logic capcomp_select_low;
    logic ext_clock_sync_disable;
    logic clock_source_select;
    logic counter_run;
  } tmb_control_t;

  // operating modes
  typedef enum logic [1:0] {
    TMB_MODE_TIMER = 2'b00,
    TMB_MODE_SYNC = 2'b01,
    TMB_MODE_ASYNC = 2'b10
  } tmb_mode_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tmb_apb_req_t;

  // time base routing to the two capture/compare units
  typedef struct packed {
    logic std_uses_this;
    logic enh_uses_this;
  } tmb_capcomp_route_t;

endpackage

// ---- core/tmb_sync.sv ----
// Purpose: two flip-flop synchroniser for pin level inputs
// Assumes: inputs are levels, slower than the core clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module tmb_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage_one;

  // two stage capture, both stages clear on reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_one <= '0;
      o_sync <= '0;
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end

endmodule

// ---- verification/tmb_timer_asserts.sv ----
// Purpose: port checker for the sixteen bit timer
// Assumes: one clock domain, control and enable mirrored from apb writes
// Notes: bound into every tmb_timer instance
`timescale 1ns/1ns
module tmb_timer_asserts
  import tmb_pkg::*;
(
  // clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input tmb_apb_req_t i_apb,
  // pins and events
  input wire logic i_companion_osc_enable,
  input wire logic [1:0] i_port_c_direction,
  input wire logic i_special_event,
  // outputs under watch
  input wire logic [1:0] o_osc_pin_dir,
  input wire logic [1:0] o_osc_pin_read,
  input wire logic o_overflow_irq,
  input tmb_capcomp_route_t o_capcomp_route,
  input wire logic [15:0] o_count
);
  logic [7:0] ctl;
  logic ena;
  logic wr;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // any write access at its taking edge
  assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite;
  // mirror updates at the same edge as the design registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctl <= 8'h00;
      ena <= 1'b0;
    end else if (wr && i_apb.paddr == TMB_OFF_CONTROL) begin
      ctl <= i_apb.pwdata[7:0];
    end else if (wr && i_apb.paddr == TMB_OFF_ENABLES) begin
      ena <= i_apb.pwdata[0];
    end
  end
  sequence s_wrap;
    o_count == 16'hffff && !wr && !i_special_event ##1 o_count == 16'h0000;
  endsequence
  property p_wrap;
    s_wrap |-> o_overflow_irq == ena;
  endproperty
  property p_event;
    i_special_event && !wr && !(ctl[1] && ctl[2]) |=> o_count == 16'h0000;
  endproperty
  property p_noflag;
    !o_overflow_irq && i_special_event && !wr && !ctl[1] |=> !o_overflow_irq;
  endproperty
  property p_lowwr;
    wr && i_apb.paddr == TMB_OFF_COUNT_LOW
      |=> o_count[7:0] == $past(i_apb.pwdata[7:0]);
  endproperty
  property p_widehi;
    wr && i_apb.paddr == TMB_OFF_COUNT_HIGH && ctl[7] && !ctl[0]
      && !i_special_event |=> $stable(o_count);
  endproperty
  property p_hold;
    !ctl[0] && !wr && !i_special_event |=> $stable(o_count);
  endproperty
  property p_tick;
    ctl[0] && !ctl[1] && ctl[5:4] == 2'b00 && !wr && !i_special_event
      |=> o_count == $past(o_count) + 16'h0001;
  endproperty
  property p_route;
    o_capcomp_route.std_uses_this == ctl[6]
      && o_capcomp_route.enh_uses_this == (ctl[6] | ctl[3]);
  endproperty
  property p_pins;
    i_companion_osc_enable |-> o_osc_pin_dir == 2'b11 && o_osc_pin_read == 2'b00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap irq wrong");
  a_event: assert property (p_event) else $error("no event reset");
  a_noflag: assert property (p_noflag) else $error("event set flag");
  a_lowwr: assert property (p_lowwr) else $error("low write lost");
  a_widehi: assert property (p_widehi) else $error("high hit count");
  a_hold: assert property (p_hold) else $error("count moved");
  a_tick: assert property (p_tick) else $error("no tick");
  a_route: assert property (p_route) else $error("bad route");
  a_pins: assert property (p_pins) else $error("pins not inputs");
endmodule

bind tmb_timer tmb_timer_asserts chk_u (.i_core_clk, .i_rst_n, .i_apb,
  .i_companion_osc_enable, .i_port_c_direction, .i_special_event,
  .o_osc_pin_dir, .o_osc_pin_read, .o_overflow_irq, .o_capcomp_route,
  .o_count);

// ---- verification/tmb_clk_partner.sv ----
// Purpose: external clock source beside the timer pins
// Assumes: each phase lasts three core cycles, above the two needed
// Notes: lines stand high between bursts, so a fall comes first
`timescale 1ns/1ns
module tmb_clk_partner (
  // core clock
  input wire logic i_core_clk,
  // pin and oscillator levels
  output logic [1:0] o_pins,
  output logic o_osc
);
  initial begin
    o_pins = 2'b01;
    o_osc = 1'b1;
  end
  // falls then rises on the chosen line
  task automatic pulse(input int n, input bit use_osc);
    repeat (n) begin
      repeat (3) @(posedge i_core_clk);
      if (use_osc) o_osc <= 1'b0;
      else o_pins[0] <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      if (use_osc) o_osc <= 1'b1;
      else o_pins[0] <= 1'b1;
    end
  endtask
endmodule

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the sixteen bit timer
// Assumes: zero wait state apb slave, pulses from tmb_clk_partner
// Notes: prescale checks allow one count of phase slack
`timescale 1ns/1ns
module testbench;
  import tmb_pkg::*;
  localparam logic [7:0] CT = TMB_OFF_CONTROL;
  localparam logic [7:0] LO = TMB_OFF_COUNT_LOW;
  localparam logic [7:0] HI = TMB_OFF_COUNT_HIGH;
  localparam logic [7:0] FL = TMB_OFF_FLAGS;
  localparam logic [7:0] EN = TMB_OFF_ENABLES;
  localparam logic [7:0] ST = TMB_OFF_STATUS;
  logic clk, rst_n, sev, osc_en, osc, pready, pslverr, irq, err;
  logic [1:0] dirs, pins, pdir, pread;
  logic [31:0] prdata, rd;
  logic [15:0] cnt, v;
  tmb_apb_req_t req;
  tmb_capcomp_route_t route;
  int n_mismatch, checked, cyc, seed, t0, d, ext_n;
  bit sev_wr;

  tmb_timer dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_apb(req),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_companion_osc_enable(osc_en), .i_companion_osc_clk(osc),
    .i_osc_pins(pins), .i_port_c_direction(dirs), .i_special_event(sev),
    .o_osc_pin_dir(pdir), .o_osc_pin_read(pread), .o_overflow_irq(irq),
    .o_capcomp_route(route), .o_count(cnt));
  tmb_clk_partner part_u (.i_core_clk(clk), .o_pins(pins), .o_osc(osc));

  // free running core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; outputs looked at once the edge has settled
  task automatic apb(input bit w, input logic [7:0] a, input logic [31:0] dt);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, dt};
    @(posedge clk);
    req.penable <= 1'b1;
    sev <= sev_wr;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    sev <= 1'b0;
    @(negedge clk);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    seed = 32'h1660;
    rst_n = 1'b0;
    req = '0;
    sev = 1'b0;
    osc_en = 1'b0;
    dirs = 2'b10;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, CT, 0); check(rd, 0);
    check(err, 1'b0);
    apb(0, ST, 0); check(rd, 0);
    // unmapped word is refused; error flag and data checked apart
    apb(0, 8'h18, 0);
    check(err, 1'b1);
    check(rd, 0);
    check(pready, 1'b1);
    // all four routing patterns
    for (int i = 0; i < 4; i++) begin
      apb(1, CT, {1'b0, i[1], 2'b00, i[0], 3'b000});
      check(route, {i[1], i[1] | i[0]});
    end
    // each prescale from a cleared prescaler, sync bit set and ignored
    for (int p = 0; p < 4; p++) begin
      apb(1, LO, 0);
      apb(1, HI, 0);
      apb(1, CT, {2'b00, p[1:0], 4'b0101});
      t0 = cyc;
      repeat (40) @(posedge clk);
      apb(1, CT, 0);
      d = (cyc - t0) >> p;
      check(cnt + 1 >= d && cnt <= d + 1, 1);
    end
    // wide mode: buffered high byte, snapshot on low read
    v = 16'($random(seed));
    apb(1, CT, 8'h80);
    t0 = cnt;
    apb(1, HI, v[15:8]); check(cnt, t0);
    apb(1, LO, v[7:0]); check(cnt, v);
    apb(1, HI, 8'h5a);
    apb(0, LO, 0); check(rd, v[7:0]);
    apb(0, HI, 0); check(rd, v[15:8]);
    apb(1, CT, 0);
    apb(1, HI, ~v[15:8]); check(cnt, {~v[15:8], v[7:0]});
    // overflow latch, gating and clear
    apb(1, CT, 8'h80);
    apb(1, HI, 8'hff);
    apb(1, LO, 8'hfd);
    apb(1, EN, 1);
    apb(1, CT, 8'h81);
    repeat (4) @(posedge clk);
    apb(0, FL, 0); check(rd, 1);
    check(irq, 1);
    apb(1, EN, 0); check(irq, 0);
    apb(1, FL, 1);
    apb(0, FL, 0); check(rd, 0);
    // special event while running, then against a write
    @(posedge clk);
    sev <= 1'b1;
    @(posedge clk);
    sev <= 1'b0;
    @(negedge clk);
    check(cnt, 0);
    apb(0, FL, 0); check(rd, 0);
    sev_wr = 1'b1;
    apb(1, LO, 8'h42); check(cnt[7:0], 8'h42);
    sev_wr = 1'b0;
    // external pin, synchronised then not, then the oscillator
    apb(1, CT, 0);
    apb(1, HI, 0);
    apb(1, LO, 0);
    apb(1, CT, 8'h03);
    part_u.pulse(5, 0);
    ext_n += 5;
    repeat (6) @(posedge clk);
    check(cnt, ext_n);
    apb(0, ST, 0); check(rd, 32'h3);
    apb(1, CT, 8'h07);
    part_u.pulse(3, 0);
    ext_n += 3;
    repeat (6) @(posedge clk);
    check(cnt, ext_n);
    // oscillator enabled with the source bit already set
    @(posedge clk);
    osc_en <= 1'b1;
    part_u.pulse(2, 1);
    ext_n += 2;
    repeat (6) @(posedge clk);
    check(cnt, ext_n);
    check({pdir, pread}, 4'hc);
    apb(0, ST, 0); check(rd, 32'hd);
    @(posedge clk);
    osc_en <= 1'b0;
    dirs <= 2'($random(seed));
    repeat (4) @(posedge clk);
    check({pdir, pread}, {dirs, pins});
    end_of_test;
  end
endmodule
